/* File: hdlc_stat_pkg.sv */
// Package for the link-layer status and receive-data register block
package hdlc_stat_pkg;
   localparam logic [7:0] ADDR_RX_INFO = 8'h03;
   localparam logic [7:0] ADDR_RX_CODE = 8'h04;
   localparam logic [7:0] ADDR_RX_DATA = 8'h05;
   localparam logic [7:0] ADDR_TX_INFO = 8'h06;
   localparam logic [7:0] ADDR_LL_STATUS = 8'h01;
   localparam int ABORT_ONES = 7;
   localparam int CODE_W = 6;
   localparam logic [5:0] CODE_RESET = 6'h3F;
   localparam int FIFO_DEPTH = 64;
   // Bit positions in the receive information, receive code, transmit information and link-layer status registers
   localparam int RI_ABT = 7;
   localparam int RI_CRC = 6;
   localparam int RI_OVR = 5;
   localparam int RI_VM = 4;
   localparam int RI_EMP = 3;
   localparam int RI_POK = 2;
   localparam int RI_CB = 1;
   localparam int RI_OB = 0;
   localparam int RC_LBD = 7;
   localparam int RC_BD = 6;
   localparam int TI_EMP = 2;
   localparam int TI_FULL = 1;
   localparam int TI_UDR = 0;
   localparam int LS_CHG = 7;

   // One receive FIFO entry: data byte plus per-byte tags
   typedef struct packed {
      logic [7:0] data;
      logic opening;
      logic closing;
      logic good;
   } rx_entry_t;

   // Host parallel-port read and write access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // Events from the receive line logic
   typedef struct packed {
      logic bit_valid;
      logic bit_val;
      logic crc_bad;
      logic msg_done;
   } rx_line_t;
endpackage

/* File: hdlc_fifo_status_regs.sv */
// Receive FIFO, code detector status and transmit FIFO status registers
`timescale 1ns/10ps

module hdlc_fifo_status_regs #(
   parameter int DEPTH = hdlc_stat_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk, // System clock, 40 MHz
   input wire logic rst, // Async reset, active high
   input wire hdlc_stat_pkg::host_req_t host, // Host port request
   output logic [7:0] rdata, // Read data, registered
   input wire hdlc_stat_pkg::rx_line_t rx_line, // Receive bit stream events
   input wire logic rx_push, // Receive byte ready
   input wire hdlc_stat_pkg::rx_entry_t rx_byte, // Receive byte and tags
   input wire logic code_live, // Detector sees valid code
   input wire logic code_verify, // New code verified pulse
   input wire logic [5:0] code_in, // Verified code, bit 0 first
   input wire logic tx_empty, // Transmit FIFO empty
   input wire logic tx_full, // Transmit FIFO full
   input wire logic tx_pop_dry, // Transmit FIFO ran dry
   input wire logic tx_end_of_message, // End-of-message control bit
   output logic tx_send_abort // Pulse: send abort sequence
);
   import hdlc_stat_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // Pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two of at least 2");
   end

   rx_entry_t mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic [2:0] ones_q;
   logic abt_q, crc_q, ovr_q, vm_q, lbd_q, bd_q, chg_q, udr_q;
   logic [5:0] code_q;
   logic rx_empty, rx_fullf, do_push, do_pop;
   logic rd_info, rd_code, rd_data, rd_tx, rd_ls;
   logic abort_ev;
   rx_entry_t head;

   assign rd_info = host.rd && host.addr == ADDR_RX_INFO;
   assign rd_code = host.rd && host.addr == ADDR_RX_CODE;
   assign rd_data = host.rd && host.addr == ADDR_RX_DATA;
   assign rd_tx = host.rd && host.addr == ADDR_TX_INFO;
   assign rd_ls = host.rd && host.addr == ADDR_LL_STATUS;

   assign rx_empty = cnt_q == '0;
   assign rx_fullf = cnt_q == (AW+1)'(DEPTH);
   assign do_push = rx_push && !rx_fullf;
   assign do_pop = rd_data && !rx_empty;
   assign head = mem_q[rp_q];

   // FIFO storage and pointers
   always_ff @(posedge sys_clk) begin
      if (do_push)
         mem_q[wp_q] <= rx_byte;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push)
            wp_q <= wp_q + 1'b1;
         if (do_pop)
            rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   a_pop_count: assert property (
      @(posedge sys_clk) disable iff (rst)
      do_pop && !do_push |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("pop did not remove byte");
   a_push_count: assert property (
      @(posedge sys_clk) disable iff (rst)
      do_push && !do_pop |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("push did not add byte");
   a_full_drop: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_push && rx_fullf && !do_pop |=> cnt_q == $past(cnt_q))
      else $error("push into full fifo stored");

   // Run length of ones; saturates so long runs still count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         ones_q <= '0;
      else if (rx_line.bit_valid) begin
         if (!rx_line.bit_val)
            ones_q <= '0;
         else if (ones_q != 3'(ABORT_ONES - 1))
            ones_q <= ones_q + 1'b1;
      end
   end
   assign abort_ev = rx_line.bit_valid && rx_line.bit_val &&
                     ones_q == 3'(ABORT_ONES - 1);

   // Sticky receive flags; a new event beats the read clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         abt_q <= 1'b0;
         crc_q <= 1'b0;
         ovr_q <= 1'b0;
         vm_q <= 1'b0;
      end else begin
         abt_q <= abort_ev || (abt_q && !rd_info);
         crc_q <= rx_line.crc_bad || (crc_q && !rd_info);
         ovr_q <= (rx_push && rx_fullf) || (ovr_q && !rd_info);
         vm_q <= rx_line.msg_done || (vm_q && !rd_info);
      end
   end

   a_abort_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      abort_ev |=> abt_q)
      else $error("abort not set");
   a_crc_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_line.crc_bad |=> crc_q)
      else $error("checksum error not set");
   a_overrun_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_push && rx_fullf |=> ovr_q)
      else $error("overrun not set");
   a_vm_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_line.msg_done |=> vm_q)
      else $error("valid msg not set");
   a_info_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info && !rx_line.crc_bad |=> !crc_q)
      else $error("crc flag not cleared");
   a_abort_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info && !abort_ev |=> !abt_q)
      else $error("abort flag not cleared");
   a_ovr_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info && !(rx_push && rx_fullf) |=> !ovr_q)
      else $error("overrun flag not cleared");

   // Code detector status
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bd_q <= 1'b0;
         lbd_q <= 1'b0;
         chg_q <= 1'b0;
         code_q <= CODE_RESET;
      end else begin
         bd_q <= code_live;
         lbd_q <= code_live || (lbd_q && !rd_code);
         chg_q <= (code_live != bd_q) || (chg_q && !rd_ls);
         if (code_verify)
            code_q <= code_in;
      end
   end

   a_lbd_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      lbd_q && !rd_code |=> lbd_q)
      else $error("latched code lost");
   a_lbd_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      code_live |=> lbd_q)
      else $error("latched code not set");
   a_code_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      !code_verify |=> $stable(code_q))
      else $error("code changed");
   a_code_load: assert property (
      @(posedge sys_clk) disable iff (rst)
      code_verify |=> code_q == $past(code_in))
      else $error("verified code not loaded");
   a_bd_follow: assert property (
      @(posedge sys_clk) disable iff (rst)
      bd_q == $past(code_live))
      else $error("live code detect lags");
   a_chg_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      code_live != bd_q |=> chg_q)
      else $error("change not set");
   a_chg_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_ls && code_live == bd_q |=> !chg_q)
      else $error("change not cleared");

   // Underrun: only when not ending a message
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         udr_q <= 1'b0;
         tx_send_abort <= 1'b0;
      end else begin
         tx_send_abort <= tx_pop_dry && !tx_end_of_message;
         udr_q <= (tx_pop_dry && !tx_end_of_message) ||
                  (udr_q && !rd_tx);
      end
   end

   a_udr_abort: assert property (
      @(posedge sys_clk) disable iff (rst)
      tx_pop_dry && !tx_end_of_message |=> tx_send_abort && udr_q)
      else $error("underrun not handled");
   a_eom_quiet: assert property (
      @(posedge sys_clk) disable iff (rst)
      tx_pop_dry && tx_end_of_message |=> !tx_send_abort)
      else $error("abort sent at message end");
   a_udr_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_tx && !tx_pop_dry |=> !udr_q)
      else $error("underrun kept");

   // Read mux; unused transmit bits read zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         rdata <= '0;
      else begin
         rdata <= '0;
         case (host.addr)
            ADDR_RX_INFO: begin
               rdata[RI_ABT] <= abt_q;
               rdata[RI_CRC] <= crc_q;
               rdata[RI_OVR] <= ovr_q;
               rdata[RI_VM] <= vm_q;
               rdata[RI_EMP] <= rx_empty;
               rdata[RI_POK] <= !rx_empty && head.closing && head.good;
               rdata[RI_CB] <= !rx_empty && head.closing;
               rdata[RI_OB] <= !rx_empty && head.opening;
            end
            ADDR_RX_CODE:
               rdata <= {lbd_q, bd_q, code_q};
            ADDR_RX_DATA:
               rdata <= rx_empty ? 8'h00 : head.data;
            ADDR_TX_INFO: begin
               rdata[TI_EMP] <= tx_empty;
               rdata[TI_FULL] <= tx_full;
               rdata[TI_UDR] <= udr_q;
            end
            ADDR_LL_STATUS:
               rdata[LS_CHG] <= chg_q;
            default:
               rdata <= '0;
         endcase
      end
   end

   a_empty_live: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info |=> rdata[RI_EMP] == $past(rx_empty))
      else $error("empty flag wrong");
   a_pok_close: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info |=> !rdata[RI_POK] || rdata[RI_CB])
      else $error("packet good without closing byte");
   a_empty_noflag: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_info |=> !rdata[RI_EMP] || rdata[RI_CB:RI_OB] == '0)
      else $error("byte flags shown for empty fifo");
   a_data_head: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_data && !rx_empty |=> rdata == $past(head.data))
      else $error("data read not head byte");
   a_code_read: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_code |=> rdata[CODE_W-1:0] == $past(code_q))
      else $error("code bits read wrong");
   a_tx_empty: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_tx |=> rdata[TI_EMP] == $past(tx_empty))
      else $error("transmit empty read wrong");
   a_tx_full: assert property (
      @(posedge sys_clk) disable iff (rst)
      rd_tx |=> rdata[TI_FULL] == $past(tx_full))
      else $error("transmit full read wrong");

   c_fifo_full: cover property (@(posedge sys_clk) disable iff (rst)
      rx_fullf);
   c_underrun: cover property (@(posedge sys_clk) disable iff (rst)
      tx_send_abort);
   c_pop_close: cover property (@(posedge sys_clk) disable iff (rst)
      do_pop && head.closing);
   c_abort_run: cover property (@(posedge sys_clk) disable iff (rst)
      abort_ev);
   c_code_change: cover property (@(posedge sys_clk) disable iff (rst)
      rd_ls && chg_q);
endmodule // hdlc_fifo_status_regs

/* File: host_port_model.sv */
// Host processor model on the parallel control port
`timescale 1ns/10ps
module host_port_model (
   input wire logic sys_clk, // System clock
   output hdlc_stat_pkg::host_req_t host, // Request to block
   input wire logic [7:0] rdata // Registered read data
);
   import hdlc_stat_pkg::*;
   initial host = '0;
   // Strobe for one edge; registered data is taken at the edge after
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      host.rd <= 1'b0;
      @(posedge sys_clk);
      d = rdata;
      if (a == ADDR_TX_INFO) begin
         d = d & 8'h07;
      end
   endtask
endmodule // host_port_model

/* File: tb_hdlc_fifo_status_regs.sv */
// Self-checking bench for the status register block
`timescale 1ns/10ps
module tb_hdlc_fifo_status_regs;
   import hdlc_stat_pkg::*;
   localparam int DEP = 4;
   logic sys_clk, rst, rx_push, code_live, code_verify, tx_send_abort;
   logic tx_empty, tx_full, tx_pop_dry, tx_end_of_message;
   logic [5:0] code_in;
   logic [7:0] rdata, d;
   host_req_t host;
   rx_line_t rx_line;
   rx_entry_t rx_byte;
   int err_total = 0;
   int n_tests = 0;
   int aborts = 0;
   hdlc_fifo_status_regs #(.DEPTH(DEP)) u_hdlc_fifo_status_regs (
      .sys_clk(sys_clk), .rst(rst), .host(host), .rdata(rdata),
      .rx_line(rx_line), .rx_push(rx_push), .rx_byte(rx_byte),
      .code_live(code_live), .code_verify(code_verify),
      .code_in(code_in), .tx_empty(tx_empty), .tx_full(tx_full),
      .tx_pop_dry(tx_pop_dry), .tx_end_of_message(tx_end_of_message),
      .tx_send_abort(tx_send_abort));
   host_port_model u_host_port_model (.sys_clk(sys_clk), .host(host),
      .rdata(rdata));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (tx_send_abort === 1'b1) aborts++;
   task automatic finish_test;
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, exp);
      u_host_port_model.rd(a, d);
      chk(d, exp);
   endtask
   task automatic line(input int n, input rx_line_t v);
      repeat (n) @(posedge sys_clk) rx_line <= v;
      @(posedge sys_clk) rx_line <= '0;
   endtask
   task automatic push(input logic [7:0] b, input logic o, c, g);
      @(posedge sys_clk);
      rx_push <= 1'b1;
      rx_byte <= '{data: b, opening: o, closing: c, good: g};
      @(posedge sys_clk) rx_push <= 1'b0;
   endtask
   task automatic t_reset;
      rdchk(ADDR_RX_CODE, 8'h3F);
      rdchk(ADDR_RX_INFO, 8'h08);
      rdchk(ADDR_TX_INFO, 8'h04);
      rdchk(8'h00, 8'h00);
   endtask
   task automatic t_line;
      line(6, '{1'b1, 1'b1, 1'b0, 1'b0});
      line(1, '{1'b1, 1'b0, 1'b0, 1'b0});
      rdchk(ADDR_RX_INFO, 8'h08);
      line(7, '{1'b1, 1'b1, 1'b0, 1'b0});
      rdchk(ADDR_RX_INFO, 8'h88);
      rdchk(ADDR_RX_INFO, 8'h08);
      line(1, '{1'b0, 1'b0, 1'b1, 1'b0});
      rdchk(ADDR_RX_INFO, 8'h48);
      line(1, '{1'b0, 1'b0, 1'b0, 1'b1});
      rdchk(ADDR_RX_INFO, 8'h18);
   endtask
   task automatic t_fifo;
      push(8'hA5, 1'b1, 1'b0, 1'b0);
      push(8'h3C, 1'b0, 1'b1, 1'b1);
      push(8'h5A, 1'b1, 1'b1, 1'b0);
      rdchk(ADDR_RX_INFO, 8'h01);
      rdchk(ADDR_RX_DATA, 8'hA5);
      rdchk(ADDR_RX_INFO, 8'h06);
      rdchk(ADDR_RX_DATA, 8'h3C);
      rdchk(ADDR_RX_INFO, 8'h03);
      rdchk(ADDR_RX_DATA, 8'h5A);
      rdchk(ADDR_RX_INFO, 8'h08);
      rdchk(ADDR_RX_DATA, 8'h00);
   endtask
   task automatic t_overrun;
      for (int i = 0; i < DEP; i++) push(8'(i + 16), 1'b0, 1'b0, 1'b0);
      rdchk(ADDR_RX_INFO, 8'h00);
      push(8'hEE, 1'b0, 1'b0, 1'b0);
      rdchk(ADDR_RX_INFO, 8'h20);
      for (int i = 0; i < DEP; i++) rdchk(ADDR_RX_DATA, 8'(i + 16));
      rdchk(ADDR_RX_INFO, 8'h08);
   endtask
   task automatic t_code;
      @(posedge sys_clk);
      code_live <= 1'b1;
      code_in <= 6'h25;
      code_verify <= 1'b1;
      @(posedge sys_clk) code_verify <= 1'b0;
      rdchk(ADDR_RX_CODE, 8'hE5);
      u_host_port_model.rd(ADDR_LL_STATUS, d);
      chk(d & 8'h80, 8'h80);
      @(posedge sys_clk);
      code_live <= 1'b0;
      code_in <= 6'h00;
      repeat (2) @(posedge sys_clk);
      rdchk(ADDR_RX_CODE, 8'hA5);
      rdchk(ADDR_RX_CODE, 8'h25);
      u_host_port_model.rd(ADDR_LL_STATUS, d);
      chk(d & 8'h80, 8'h80);
      u_host_port_model.rd(ADDR_LL_STATUS, d);
      chk(d & 8'h80, 8'h00);
   endtask
   task automatic t_tx;
      @(posedge sys_clk);
      tx_empty <= 1'b0;
      tx_full <= 1'b1;
      rdchk(ADDR_TX_INFO, 8'h02);
      @(posedge sys_clk);
      tx_full <= 1'b0;
      tx_end_of_message <= 1'b1;
      tx_pop_dry <= 1'b1;
      @(posedge sys_clk) tx_pop_dry <= 1'b0;
      rdchk(ADDR_TX_INFO, 8'h00);
      @(posedge sys_clk);
      tx_end_of_message <= 1'b0;
      tx_empty <= 1'b1;
      tx_pop_dry <= 1'b1;
      @(posedge sys_clk) tx_pop_dry <= 1'b0;
      rdchk(ADDR_TX_INFO, 8'h05);
      chk(8'(aborts), 8'h01);
      rdchk(ADDR_TX_INFO, 8'h04);
   endtask
   task automatic t_midreset;
      push(8'h77, 1'b1, 1'b1, 1'b1);
      line(1, '{1'b0, 1'b0, 1'b1, 1'b0});
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(ADDR_RX_INFO, 8'h08);
      rdchk(ADDR_RX_CODE, 8'h3F);
   endtask
   initial begin
      rst = 1'b1;
      {rx_push, code_live, code_verify, tx_full, tx_pop_dry} = '0;
      {tx_end_of_message, code_in, rx_line, rx_byte} = '0;
      tx_empty = 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_line();
      t_fifo();
      t_overrun();
      t_code();
      t_tx();
      t_midreset();
      finish_test();
   end
   // Whole run is well under 300 cycles; this margin only catches hangs
   initial begin
      #100000;
      err_total++;
      finish_test();
   end
endmodule // tb_hdlc_fifo_status_regs
